// ===== core/dcs_config_regs.sv
// Configuration and status register bank of the link deserializer
`timescale 1ns/1ps
// Behaviour
// - Lock flag mirrors link acquired output
// - Outputs enabled while outputs_off is zero
// - Pattern test off after power-up
// - Sleep default from control pins
// - Protocol select resets to I2C
// - Both control channels enabled at power-up
// - Master sends register address by default
// - Corner 3.75MHz, HF boost on (boost-off bit clear) at power-up
// - Boost level preset from eq pin
// - Error auto clear defaults off
// - Interrupt forwarded unless disabled; line readable
// - Pins driven from drive bits, levels readable
// - Decode error limit resets to zero
// - Decode error counter, read only
// - Pattern error counter, read only
// - Audio clock source and divider, zero disables
// - Bit 27 routed to aux and spare
// - Output current 3.5mA, no force
// - Normal driver strength by default
// - Capability register: zeros, no protection, revision
// - Power-up address from two strap pins
// - Bit 4 set only in deserializer address
module dcs_config_regs #(
   parameter logic [7:0] DEVICE_CODE = 8'h5A, // Arbitrary value
   parameter logic [3:0] REVISION = 4'h1 // Arbitrary value
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic reg_rack,
   input wire logic link_lock,
   input wire logic irq_req,
   input wire logic remote_irq,
   input wire logic decode_err,
   input wire logic pattern_err,
   input wire logic rx_bit27,
   input wire logic ctl_dir_sel_pin,
   input wire logic ctl_link_mode_pin,
   input wire logic eq_preset_pin,
   input wire logic [1:0] gp_pin_in,
   input wire logic [1:0] strap_hi_pin,
   input wire logic [1:0] strap_lo_pin,
   output logic link_acquired_out,
   output logic outputs_on,
   output logic test_pattern_on,
   output logic sleep_on,
   output logic [1:0] base_link_protocol_sel,
   output logic back_ctl_chan_on,
   output logic fwd_ctl_chan_on,
   output logic master_regaddr_mode,
   output logic [1:0] eq_hpf_corner,
   output logic hf_boost_off,
   output logic [3:0] eq_boost_level,
   output logic err_auto_clear,
   output logic irq_forward,
   output logic decode_err_over,
   output logic [1:0] gp_pin_out,
   output logic audio_clk_source,
   output logic audio_clk_out,
   output logic aux1_out,
   output logic spare_bit_out,
   output logic [1:0] diff_out_current,
   output logic diff_out_force,
   output logic cmos_drive_strength,
   output logic [7:0] ser_addr_default,
   output logic [7:0] des_addr_default
);
   logic [dcs_pkg::SYNC_W-1:0] pins_async;
   logic [dcs_pkg::SYNC_W-1:0] pins_s;
   logic dir_sel_s;
   logic link_mode_s;
   logic eq_preset_s;
   logic [1:0] gp_lvl_s;
   logic [1:0] strap_hi_s;
   logic [1:0] strap_lo_s;
   logic [1:0] settle_reg;
   logic strap_done_reg;
   logic strap_take;
   logic [7:0] link_reg;
   logic [7:0] eq_reg;
   logic [7:0] irqgp_reg;
   logic [7:0] rsv_reg [0:5];
   logic [7:0] thr_reg;
   logic [7:0] deccnt_reg;
   logic [7:0] deccnt_next;
   logic [7:0] patcnt_reg;
   logic [7:0] patcnt_next;
   logic [7:0] aud_reg;
   logic [7:0] drv_reg;
   logic [6:0] div_cnt_reg;
   logic [6:0] aud_ratio;
   logic wr_link;
   logic wr_eq;
   logic wr_irqgp;
   logic rd_deccnt;
   logic rd_patcnt;
   logic pat_start;
   logic pat_on_d_reg;
   logic [7:0] rd_mux;

   // High bits of a strap: low gives 10, high 11, open 01
   function automatic logic [1:0] strap_hi_bits(input logic [1:0] code);
      case (code)
         dcs_pkg::STRAP_LOW: strap_hi_bits = 2'h2;
         dcs_pkg::STRAP_HIGH: strap_hi_bits = 2'h3;
         default: strap_hi_bits = 2'h1;
      endcase
   endfunction

   // Low strap: low gives 00, high 01, open 10
   function automatic logic [1:0] strap_lo_bits(input logic [1:0] code);
      case (code)
         dcs_pkg::STRAP_LOW: strap_lo_bits = 2'h0;
         dcs_pkg::STRAP_HIGH: strap_lo_bits = 2'h1;
         default: strap_lo_bits = 2'h2;
      endcase
   endfunction

   // Saturating event counter with set-over-clear
   function automatic logic [7:0] count_step(input logic [7:0] cur,
                                             input logic clr,
                                             input logic ev);
      logic [7:0] base;
      base = clr ? dcs_pkg::CNT_ZERO : cur;
      if (ev && base != dcs_pkg::CNT_MAX)
         count_step = base + dcs_pkg::CNT_ONE;
      else
         count_step = base;
   endfunction

   // Pins from outside are brought onto ref_clk first
   assign pins_async = {strap_lo_pin, strap_hi_pin, gp_pin_in,
                        eq_preset_pin, ctl_link_mode_pin, ctl_dir_sel_pin};

   dcs_pin_sync #(
      .W(dcs_pkg::SYNC_W)
   ) u_sync (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .pin_in(pins_async),
      .pin_sync(pins_s)
   );

   assign dir_sel_s = pins_s[0];
   assign link_mode_s = pins_s[1];
   assign eq_preset_s = pins_s[2];
   assign gp_lvl_s = pins_s[4:3];
   assign strap_hi_s = pins_s[6:5];
   assign strap_lo_s = pins_s[8:7];

   // One sampling strobe once the synchronisers have settled
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         settle_reg <= 2'h0;
         strap_done_reg <= 1'b0;
      end
      else if (!strap_done_reg)
      begin
         settle_reg <= settle_reg + 2'h1;
         if (settle_reg == dcs_pkg::STRAP_SETTLE)
            strap_done_reg <= 1'b1;
      end
   end

   assign strap_take = !strap_done_reg &&
                       (settle_reg == dcs_pkg::STRAP_SETTLE);

   // Write and read strobes for registers with side effects
   assign wr_link = reg_wr && reg_addr == dcs_pkg::OFS_LINK;
   assign wr_eq = reg_wr && reg_addr == dcs_pkg::OFS_EQ;
   assign wr_irqgp = reg_wr && reg_addr == dcs_pkg::OFS_IRQGP;
   assign rd_deccnt = reg_rd && reg_addr == dcs_pkg::OFS_DECCNT;
   assign rd_patcnt = reg_rd && reg_addr == dcs_pkg::OFS_PATCNT;

   // Link control; the lock bit is never stored from a write
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
         link_reg <= dcs_pkg::RST_LINK;
      else if (strap_take)
         link_reg[dcs_pkg::B_SLEEP] <= dir_sel_s & ~link_mode_s;
      else if (wr_link)
         link_reg <= {1'b0, reg_wdata[6:0]};
   end

   // Equalizer tuning; boost preset taken once from the pin
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
         eq_reg <= dcs_pkg::RST_EQ_HI;
      else if (strap_take)
         eq_reg[3:0] <= eq_preset_s ? dcs_pkg::EQ_BOOST_HI
                                    : dcs_pkg::EQ_BOOST_LO;
      else if (wr_eq)
         eq_reg <= reg_wdata;
   end

   // Interrupt and pin control; only drive and control bits stored
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
         irqgp_reg <= dcs_pkg::RST_IRQGP;
      else if (wr_irqgp)
      begin
         irqgp_reg[dcs_pkg::B_AUTOCLR] <= reg_wdata[dcs_pkg::B_AUTOCLR];
         irqgp_reg[dcs_pkg::B_IRQDIS] <= reg_wdata[dcs_pkg::B_IRQDIS];
         irqgp_reg[dcs_pkg::B_GP1DRV] <= reg_wdata[dcs_pkg::B_GP1DRV];
         irqgp_reg[dcs_pkg::B_GP0DRV] <= reg_wdata[dcs_pkg::B_GP0DRV];
      end
   end

   // Reserved storage keeps whatever software writes
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         rsv_reg[0] <= dcs_pkg::RST_RSVA;
         rsv_reg[1] <= dcs_pkg::RST_RSVB;
         rsv_reg[2] <= dcs_pkg::RST_RSVC;
         rsv_reg[3] <= dcs_pkg::RST_RSVD;
         rsv_reg[4] <= dcs_pkg::RST_RSVE;
         rsv_reg[5] <= dcs_pkg::RST_RSVF;
      end
      else if (reg_wr)
      begin
         case (reg_addr)
            dcs_pkg::OFS_RSVA: rsv_reg[0] <= reg_wdata;
            dcs_pkg::OFS_RSVB: rsv_reg[1] <= reg_wdata;
            dcs_pkg::OFS_RSVC: rsv_reg[2] <= reg_wdata;
            dcs_pkg::OFS_RSVD: rsv_reg[3] <= reg_wdata;
            dcs_pkg::OFS_RSVE: rsv_reg[4] <= reg_wdata;
            dcs_pkg::OFS_RSVF: rsv_reg[5] <= reg_wdata;
            default: ;
         endcase
      end
   end

   // Plain writable control registers
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         thr_reg <= dcs_pkg::RST_THR;
         aud_reg <= dcs_pkg::RST_AUDCLK;
         drv_reg <= dcs_pkg::RST_DRV;
      end
      else if (reg_wr)
      begin
         case (reg_addr)
            dcs_pkg::OFS_THR: thr_reg <= reg_wdata;
            dcs_pkg::OFS_AUDCLK: aud_reg <= reg_wdata;
            dcs_pkg::OFS_DRV: drv_reg <= reg_wdata;
            default: ;
         endcase
      end
   end

   // Error counters; a clearing read loses no coincident error
   assign deccnt_next = count_step(deccnt_reg,
      rd_deccnt && irqgp_reg[dcs_pkg::B_AUTOCLR], decode_err);
   assign pat_start = link_reg[dcs_pkg::B_PATON] && !pat_on_d_reg;
   assign patcnt_next = count_step(patcnt_reg,
      pat_start || (rd_patcnt && irqgp_reg[dcs_pkg::B_AUTOCLR]),
      pattern_err && link_reg[dcs_pkg::B_PATON]);

   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         deccnt_reg <= dcs_pkg::CNT_ZERO;
         patcnt_reg <= dcs_pkg::CNT_ZERO;
         pat_on_d_reg <= 1'b0;
      end
      else
      begin
         deccnt_reg <= deccnt_next;
         patcnt_reg <= patcnt_next;
         pat_on_d_reg <= link_reg[dcs_pkg::B_PATON];
      end
   end

   // Audio clock divider; odd ratios give a short high phase
   assign aud_ratio = aud_reg[6:0];

   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
         div_cnt_reg <= 7'h00;
      else if (aud_ratio == 7'h00 || div_cnt_reg >= aud_ratio - 7'h01)
         div_cnt_reg <= 7'h00;
      else
         div_cnt_reg <= div_cnt_reg + 7'h01;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
         audio_clk_out <= 1'b0;
      else if (aud_ratio == 7'h00)
         audio_clk_out <= 1'b0;
      else
         audio_clk_out <= div_cnt_reg < (aud_ratio >> 1);
   end

   // Read data mux; live hardware values replace stored ones
   always_comb
   begin
      rd_mux = 8'h00;
      case (reg_addr)
         dcs_pkg::OFS_LINK:
            rd_mux = {link_acquired_out, link_reg[6:0]};
         dcs_pkg::OFS_EQ: rd_mux = eq_reg;
         dcs_pkg::OFS_IRQGP:
            rd_mux = {1'b0, irqgp_reg[6:5], remote_irq,
                      irqgp_reg[3], gp_lvl_s[1],
                      irqgp_reg[1], gp_lvl_s[0]};
         dcs_pkg::OFS_RSVA: rd_mux = rsv_reg[0];
         dcs_pkg::OFS_RSVB: rd_mux = rsv_reg[1];
         dcs_pkg::OFS_RSVC: rd_mux = rsv_reg[2];
         dcs_pkg::OFS_RSVD: rd_mux = rsv_reg[3];
         dcs_pkg::OFS_RSVE: rd_mux = rsv_reg[4];
         dcs_pkg::OFS_THR: rd_mux = thr_reg;
         dcs_pkg::OFS_DECCNT: rd_mux = deccnt_reg;
         dcs_pkg::OFS_PATCNT: rd_mux = patcnt_reg;
         dcs_pkg::OFS_AUDCLK: rd_mux = aud_reg;
         dcs_pkg::OFS_RSVF: rd_mux = rsv_reg[5];
         dcs_pkg::OFS_DRV: rd_mux = drv_reg;
         dcs_pkg::OFS_IDENT: rd_mux = DEVICE_CODE;
         dcs_pkg::OFS_CAPREV: rd_mux = {3'h0, 1'b0, REVISION};
         default: rd_mux = 8'h00;
      endcase
   end

   // Read answer one cycle after the strobe
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         reg_rdata <= 8'h00;
         reg_rack <= 1'b0;
      end
      else
      begin
         reg_rack <= reg_rd;
         if (reg_rd)
            reg_rdata <= rd_mux;
      end
   end

   // Power-up device addresses, bits 5 and 1 and R/W held at zero
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         ser_addr_default <= 8'h00;
         des_addr_default <= 8'h00;
      end
      else if (strap_take)
      begin
         ser_addr_default <= {strap_hi_bits(strap_hi_s), 1'b0, 1'b0,
                              strap_lo_bits(strap_lo_s), 2'h0};
         des_addr_default <= {strap_hi_bits(strap_hi_s), 1'b0, 1'b1,
                              strap_lo_bits(strap_lo_s), 2'h0};
      end
   end

   // Status and control outputs, all from flops
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         link_acquired_out <= 1'b0;
         irq_forward <= 1'b0;
         decode_err_over <= 1'b0;
         aux1_out <= 1'b0;
         spare_bit_out <= 1'b0;
      end
      else
      begin
         link_acquired_out <= link_lock;
         irq_forward <= irq_req && !irqgp_reg[dcs_pkg::B_IRQDIS];
         decode_err_over <= deccnt_next > thr_reg;
         aux1_out <= rx_bit27 && !drv_reg[dcs_pkg::B_AUXLOW];
         spare_bit_out <= rx_bit27 && !drv_reg[dcs_pkg::B_SPRLOW];
      end
   end

   // Registered copies of configuration fields
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         outputs_on <= 1'b1;
         test_pattern_on <= 1'b0;
         sleep_on <= 1'b0;
         base_link_protocol_sel <= 2'h0;
         back_ctl_chan_on <= 1'b1;
         fwd_ctl_chan_on <= 1'b1;
         master_regaddr_mode <= 1'b0;
         eq_hpf_corner <= 2'h1;
         hf_boost_off <= 1'b0;
         eq_boost_level <= dcs_pkg::EQ_BOOST_HI;
         err_auto_clear <= 1'b0;
         gp_pin_out <= 2'h3;
         audio_clk_source <= 1'b0;
         diff_out_current <= 2'h1;
         diff_out_force <= 1'b0;
         cmos_drive_strength <= 1'b0;
      end
      else
      begin
         outputs_on <= !link_reg[dcs_pkg::B_OUTOFF];
         test_pattern_on <= link_reg[dcs_pkg::B_PATON];
         sleep_on <= link_reg[dcs_pkg::B_SLEEP];
         base_link_protocol_sel <= link_reg[3:2];
         back_ctl_chan_on <= link_reg[dcs_pkg::B_BACKCC];
         fwd_ctl_chan_on <= link_reg[dcs_pkg::B_FWDCC];
         master_regaddr_mode <= eq_reg[dcs_pkg::B_REGADDR];
         eq_hpf_corner <= eq_reg[6:5];
         hf_boost_off <= eq_reg[dcs_pkg::B_HFOFF];
         eq_boost_level <= eq_reg[3:0];
         err_auto_clear <= irqgp_reg[dcs_pkg::B_AUTOCLR];
         gp_pin_out <= {irqgp_reg[dcs_pkg::B_GP1DRV],
                        irqgp_reg[dcs_pkg::B_GP0DRV]};
         audio_clk_source <= aud_reg[dcs_pkg::B_AUDSRC];
         diff_out_current <= drv_reg[1:0];
         diff_out_force <= drv_reg[dcs_pkg::B_DFORCE];
         cmos_drive_strength <= drv_reg[dcs_pkg::B_CMOSDS];
      end
   end
endmodule // dcs_config_regs

// ===== core/dcs_pin_sync.sv
// Two-stage synchroniser for the asynchronous pin inputs
`timescale 1ns/1ps
module dcs_pin_sync #(
   parameter int W = 1
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] pin_sync
);
   logic [W-1:0] meta_reg;

   // First stage feeds only the second stage
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         meta_reg <= '0;
         pin_sync <= '0;
      end
      else
      begin
         meta_reg <= pin_in;
         pin_sync <= meta_reg;
      end
   end
endmodule // dcs_pin_sync

// ===== core/dcs_pkg.sv
// Constants for the deserializer configuration and status bank
package dcs_pkg;
   // Register offsets
   localparam logic [7:0] OFS_LINK = 8'h04;
   localparam logic [7:0] OFS_EQ = 8'h05;
   localparam logic [7:0] OFS_IRQGP = 8'h06;
   localparam logic [7:0] OFS_RSVA = 8'h07;
   localparam logic [7:0] OFS_RSVB = 8'h08;
   localparam logic [7:0] OFS_RSVC = 8'h09;
   localparam logic [7:0] OFS_RSVD = 8'h0A;
   localparam logic [7:0] OFS_RSVE = 8'h0B;
   localparam logic [7:0] OFS_THR = 8'h0C;
   localparam logic [7:0] OFS_DECCNT = 8'h0D;
   localparam logic [7:0] OFS_PATCNT = 8'h0E;
   localparam logic [7:0] OFS_AUDCLK = 8'h12;
   localparam logic [7:0] OFS_RSVF = 8'h13;
   localparam logic [7:0] OFS_DRV = 8'h14;
   localparam logic [7:0] OFS_IDENT = 8'h1E;
   localparam logic [7:0] OFS_CAPREV = 8'h1F;

   // Reset values of writable storage; counter zero, step and limit
   localparam logic [7:0] RST_LINK = 8'h03;
   localparam logic [7:0] RST_EQ_HI = 8'h24;
   localparam logic [7:0] RST_IRQGP = 8'h0F;
   localparam logic [7:0] RST_RSVA = 8'h54;
   localparam logic [7:0] RST_RSVB = 8'h30;
   localparam logic [7:0] RST_RSVC = 8'hC8;
   localparam logic [7:0] RST_RSVD = 8'h12;
   localparam logic [7:0] RST_RSVE = 8'h20;
   localparam logic [7:0] RST_THR = 8'h00;
   localparam logic [7:0] RST_AUDCLK = 8'h00;
   localparam logic [7:0] RST_RSVF = 8'h10;
   localparam logic [7:0] RST_DRV = 8'h01;
   localparam logic [7:0] CNT_ZERO = 8'h00;
   localparam logic [7:0] CNT_MAX = 8'hFF;
   localparam logic [7:0] CNT_ONE = 8'h01;

   // Field positions
   localparam int B_LOCK = 7;
   localparam int B_OUTOFF = 6;
   localparam int B_PATON = 5;
   localparam int B_SLEEP = 4;
   localparam int B_BACKCC = 1;
   localparam int B_FWDCC = 0;
   localparam int B_REGADDR = 7;
   localparam int B_HFOFF = 4;
   localparam int B_AUTOCLR = 6;
   localparam int B_IRQDIS = 5;
   localparam int B_IRQLVL = 4;
   localparam int B_GP1DRV = 3;
   localparam int B_GP1LVL = 2;
   localparam int B_GP0DRV = 1;
   localparam int B_GP0LVL = 0;
   localparam int B_AUDSRC = 7;
   localparam int B_DFORCE = 5;
   localparam int B_CMOSDS = 4;
   localparam int B_AUXLOW = 3;
   localparam int B_SPRLOW = 2;

   // Equalizer boost presets
   localparam logic [3:0] EQ_BOOST_HI = 4'h4;
   localparam logic [3:0] EQ_BOOST_LO = 4'h9;

   // Three-level strap codes from the pad detector
   localparam logic [1:0] STRAP_LOW = 2'h0;
   localparam logic [1:0] STRAP_HIGH = 2'h1;
   localparam logic [1:0] STRAP_OPEN = 2'h2;

   // Cycles after reset release before pins are sampled
   localparam logic [1:0] STRAP_SETTLE = 2'h3;
   localparam int SYNC_W = 9;
endpackage

// ===== verif/dcs_config_props.sv
// Concurrent checks on the register bank ports
`timescale 1ns/1ps
module dcs_config_props (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rack,
   input wire logic link_lock,
   input wire logic rx_bit27,
   input wire logic link_acquired_out,
   input wire logic outputs_on,
   input wire logic test_pattern_on,
   input wire logic sleep_on,
   input wire logic back_ctl_chan_on,
   input wire logic fwd_ctl_chan_on,
   input wire logic [1:0] gp_pin_out,
   input wire logic audio_clk_out,
   input wire logic aux1_out,
   input wire logic spare_bit_out,
   input wire logic [7:0] ser_addr_default,
   input wire logic [7:0] des_addr_default
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   // Write then two quiet cycles, so both latencies have landed
   sequence wr_quiet(logic [7:0] a);
      reg_wr && reg_addr == a ##1 (!reg_wr) [*2];
   endsequence

   rack_after_rd_a: assert property (reg_rd |=> reg_rack)
      else $error("read not answered");
   rack_only_rd_a: assert property (!reg_rd |=> !reg_rack)
      else $error("answer without read");
   rdata_hold_a: assert property (!reg_rack |-> $stable(reg_rdata))
      else $error("read data moved");
   lock_read_a: assert property (
      reg_rd && reg_addr == dcs_pkg::OFS_LINK
      |=> reg_rdata[7] == $past(link_acquired_out))
      else $error("lock flag differs");
   lock_follow_a: assert property (
      $past(resetn) && $past(resetn, 2)
      |-> link_acquired_out == $past(link_lock))
      else $error("lock output lag");
   ctl_write_a: assert property (
      wr_quiet(dcs_pkg::OFS_LINK) |->
      outputs_on == !$past(reg_wdata[6], 2)
      && test_pattern_on == $past(reg_wdata[5], 2)
      && sleep_on == $past(reg_wdata[4], 2)
      && {back_ctl_chan_on, fwd_ctl_chan_on} == $past(reg_wdata[1:0], 2))
      else $error("link control outputs");
   gp_write_a: assert property (
      wr_quiet(dcs_pkg::OFS_IRQGP) |-> gp_pin_out ==
      {$past(reg_wdata[3], 2), $past(reg_wdata[1], 2)})
      else $error("gp drive");
   aux_route_a: assert property (
      aux1_out || spare_bit_out |-> $past(rx_bit27))
      else $error("aux without bit");
   audio_off_a: assert property (
      (reg_wr && reg_addr == dcs_pkg::OFS_AUDCLK && reg_wdata[6:0] == 7'h00)
      ##1 (!reg_wr) [*3] |-> !audio_clk_out)
      else $error("audio clock on at ratio 0");
   addr_pair_a: assert property (
      des_addr_default != 8'h00 |->
      des_addr_default == (ser_addr_default | 8'h10)
      && ser_addr_default[5:4] == 2'h0 && des_addr_default[1:0] == 2'h0)
      else $error("address pair");
endmodule // dcs_config_props

bind dcs_config_regs dcs_config_props i_dcs_config_props (
   .ref_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
   .reg_rack, .link_lock, .rx_bit27, .link_acquired_out, .outputs_on,
   .test_pattern_on, .sleep_on, .back_ctl_chan_on, .fwd_ctl_chan_on,
   .gp_pin_out, .audio_clk_out, .aux1_out, .spare_bit_out,
   .ser_addr_default, .des_addr_default);

// ===== verif/dcs_host_model.sv
// Register-port master standing in for the microcontroller
`timescale 1ns/1ps
module dcs_host_model (
   input wire logic ref_clk,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rack,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd
);
   logic [7:0] rd_val = 8'h00;

   // Idle bus at time zero
   initial
   begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end

   // One-cycle write strobe; address moves use this same path
   task automatic put(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge ref_clk);
      reg_wr = 1'b0;
      reg_addr = ~a; // Released lines must not keep old value
      reg_wdata = ~d;
   endtask

   // Answer stands one cycle, so it is taken in that cycle only
   task automatic get(input logic [7:0] a);
      @(negedge ref_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge ref_clk);
      rd_val = (reg_rack === 1'b1) ? reg_rdata : 8'hxx;
      reg_rd = 1'b0;
      reg_addr = ~a;
   endtask
endmodule // dcs_host_model

// ===== verif/tb_top.sv
// Self-checking bench for the configuration register bank
`timescale 1ns/1ps
module tb_top;
   localparam logic [7:0] DEV = 8'hA7; // Arbitrary value
   localparam logic [3:0] REV = 4'h3; // Arbitrary value
   localparam logic [7:0] RA [16] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
      8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h12, 8'h14, 8'h1E, 8'h1F,
      8'h0F};
   localparam logic [7:0] RV [16] = '{8'h13, 8'h29, 8'h0F, 8'h54, 8'h30,
      8'hC8, 8'h12, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, DEV,
      {4'h0, REV}, 8'h00};
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, ser_addr_default;
   logic [7:0] des_addr_default;
   logic reg_wr, reg_rd, reg_rack, link_acquired_out, outputs_on;
   logic test_pattern_on, sleep_on, audio_clk_out, aux1_out, spare_bit_out;
   logic [1:0] gp_pin_out;
   logic irq_forward, decode_err_over;
   logic link_lock = 1'b0;
   logic irq_req = 1'b0;
   logic remote_irq = 1'b0;
   logic decode_err = 1'b0;
   logic pattern_err = 1'b0;
   logic rx_bit27 = 1'b0;
   logic ctl_dir_sel_pin = 1'b1;
   logic ctl_link_mode_pin = 1'b0;
   logic eq_preset_pin = 1'b0;
   logic [1:0] gp_pin_in = 2'h3;
   logic [1:0] strap_hi_pin = 2'h2;
   logic [1:0] strap_lo_pin = 2'h1;
   int bad_count = 0;
   int checks = 0;
   int highs;

   // 25 MHz clock
   always #20 ref_clk = ~ref_clk;

   dcs_config_regs #(.DEVICE_CODE(DEV), .REVISION(REV)) i_dcs_config_regs (
      .ref_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .reg_rack, .link_lock, .irq_req, .remote_irq, .decode_err,
      .pattern_err, .rx_bit27, .ctl_dir_sel_pin, .ctl_link_mode_pin,
      .eq_preset_pin, .gp_pin_in, .strap_hi_pin, .strap_lo_pin,
      .link_acquired_out, .outputs_on, .test_pattern_on, .sleep_on,
      .base_link_protocol_sel(), .back_ctl_chan_on(), .fwd_ctl_chan_on(),
      .master_regaddr_mode(), .eq_hpf_corner(), .hf_boost_off(),
      .eq_boost_level(), .err_auto_clear(), .irq_forward,
      .decode_err_over, .gp_pin_out, .audio_clk_source(), .audio_clk_out,
      .aux1_out, .spare_bit_out, .diff_out_current(), .diff_out_force(),
      .cmos_drive_strength(), .ser_addr_default, .des_addr_default);

   dcs_host_model i_dcs_host_model (
      .ref_clk, .reg_rdata, .reg_rack, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd);

   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      i_dcs_host_model.get(a);
      cmp(i_dcs_host_model.rd_val, exp);
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   // Single-cycle event pulses; pat selects which counter is hit
   task automatic pulse(input int n, input logic pat);
      repeat (n)
      begin
         @(negedge ref_clk);
         decode_err = !pat;
         pattern_err = pat;
         @(negedge ref_clk);
         decode_err = 1'b0;
         pattern_err = 1'b0;
      end
   endtask

   task automatic wrap_up;
      $display("Mismatches %0d, comparisons %0d", bad_count, checks);
      if (bad_count == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Main sequence; reserved places are only read, never rewritten
   initial
   begin
      idle(3);
      resetn = 1'b1;
      idle(8); // Straps settle before first use
      for (int i = 0; i < 16; i++)
         rd(RA[i], RV[i]);
      cmp(ser_addr_default, 8'h44);
      cmp(des_addr_default, 8'h54);
      cmp({6'h0, sleep_on, outputs_on}, 8'h03);
      cmp({6'h0, decode_err_over, irq_forward}, 8'h00);
      for (int i = 13; i < 15; i++)
      begin
         i_dcs_host_model.put(RA[i], 8'hFF);
         rd(RA[i], RV[i]);
      end
      irq_req = 1'b1;
      i_dcs_host_model.put(8'h06, 8'hFF);
      rd(8'h06, 8'h6F);
      cmp({7'h0, irq_forward}, 8'h00);
      i_dcs_host_model.put(8'h06, 8'h00);
      idle(3);
      cmp({6'h0, gp_pin_out}, 8'h00);
      cmp({7'h0, irq_forward}, 8'h01);
      gp_pin_in = 2'h2;
      remote_irq = 1'b1;
      idle(4);
      rd(8'h06, 8'h14);
      i_dcs_host_model.put(8'h04, 8'hEE);
      idle(3);
      cmp({5'h0, outputs_on, test_pattern_on, sleep_on}, 8'h02);
      rd(8'h04, 8'h6E);
      link_lock = 1'b1;
      idle(3);
      rd(8'h04, 8'hEE);
      pulse(2, 1'b1);
      pulse(3, 1'b0);
      rd(8'h0E, 8'h02);
      rd(8'h0D, 8'h03);
      i_dcs_host_model.put(8'h0D, 8'h00);
      rd(8'h0D, 8'h03);
      cmp({7'h0, decode_err_over}, 8'h01);
      pulse(260, 1'b0);
      rd(8'h0D, 8'hFF);
      i_dcs_host_model.put(8'h06, 8'h4A);
      rd(8'h0D, 8'hFF);
      rd(8'h0D, 8'h00);
      cmp({7'h0, decode_err_over}, 8'h00);
      i_dcs_host_model.put(8'h06, 8'h0A);
      rx_bit27 = 1'b1;
      idle(3);
      cmp({6'h0, aux1_out, spare_bit_out}, 8'h03);
      i_dcs_host_model.put(8'h14, 8'h0D);
      idle(3);
      cmp({6'h0, aux1_out, spare_bit_out}, 8'h00);
      rd(8'h14, 8'h0D);
      i_dcs_host_model.put(8'h05, 8'hD7);
      rd(8'h05, 8'hD7);
      // Ratio 4 gives two high cycles in every four
      i_dcs_host_model.put(8'h12, 8'h04);
      idle(4);
      highs = 0;
      repeat (8)
      begin
         @(negedge ref_clk);
         highs += int'(audio_clk_out === 1'b1);
      end
      cmp(8'(highs), 8'h04);
      i_dcs_host_model.put(8'h12, 8'h00);
      idle(4);
      cmp({7'h0, audio_clk_out}, 8'h00);
      wrap_up();
   end

   // Watchdog, far beyond the roughly 660 cycles the tests need
   initial
   begin
      #400000;
      bad_count++;
      wrap_up();
   end
endmodule // tb_top
